// file: src/irs_restart_master.sv
// Two-wire master repeated-start sequencer with APB register file
`timescale 1ns/100ps
module irs_restart_master
  import irs_pkg::*;
(
  // Clock and reset
  input wire logic I_SYS_CLK,
  input wire logic I_SYS_RST,
  // APB slave
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [11:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  // Bus lines, open drain
  input wire logic I_SCL,
  output logic O_SCL,
  output logic O_SCL_OE,
  input wire logic I_SDA,
  output logic O_SDA,
  output logic O_SDA_OE,
  // Pin slew and interrupt
  output logic O_SLEW_LIMIT,
  output logic O_IRQ
);

  irs_state_t state, next_state;
  logic [6:0] baud_rate_generator, next_brg;
  logic scl_oe, next_scl_oe;
  logic sda_oe, next_sda_oe;
  logic scl_d, next_scl_d;
  logic sda_d, next_sda_d;
  logic [7:0] int_ctrl, next_int_ctrl;
  logic [7:0] flags_one, next_flags_one;
  logic [7:0] flags_two, next_flags_two;
  logic [7:0] shift_buf, next_shift_buf;
  logic [7:0] ctrl_pri, next_ctrl_pri;
  logic [7:0] ena_one, next_ena_one;
  logic [7:0] ena_two, next_ena_two;
  logic [7:0] ctrl_sec, next_ctrl_sec;
  logic [7:0] baud_reload, next_baud_reload;
  logic [7:0] status, next_status;
  logic [31:0] prdata, next_prdata;

  logic [7:0] idx;
  logic mapped;
  logic wr_acc;
  logic rd_setup;
  logic busy;
  logic start_det;
  logic stop_det;
  logic accept;
  logic coll;
  logic done;
  logic [7:0] wdat;
  logic [7:0] rmux;

  assign idx = I_PADDR[9:2];
  assign wdat = I_PWDATA[7:0];
  assign busy = (state != ST_IDLE) && (state != ST_HOLD);
  assign start_det = scl_d && I_SCL && sda_d && !I_SDA;
  assign stop_det = scl_d && I_SCL && !sda_d && I_SDA;
  assign wr_acc = I_PSEL && I_PENABLE && I_PWRITE && mapped;
  assign rd_setup = I_PSEL && !I_PENABLE && !I_PWRITE;

  // Address decode and read mux
  always_comb begin
    mapped = 1'b1;
    rmux = 8'h00;
    if (idx == IDX_INT_CTRL) begin
      rmux = int_ctrl;
    end else if (idx == IDX_FLAGS_ONE) begin
      rmux = flags_one;
    end else if (idx == IDX_FLAGS_TWO) begin
      rmux = flags_two;
    end else if (idx == IDX_SHIFT_BUF) begin
      rmux = shift_buf;
    end else if (idx == IDX_CTRL_PRI) begin
      rmux = ctrl_pri;
    end else if (idx == IDX_ENABLES_ONE) begin
      rmux = ena_one;
    end else if (idx == IDX_ENABLES_TWO) begin
      rmux = ena_two;
    end else if (idx == IDX_CTRL_SEC) begin
      rmux = ctrl_sec;
    end else if (idx == IDX_BAUD_RELOAD) begin
      rmux = baud_reload;
    end else if (idx == IDX_STATUS) begin
      rmux = status;
    end else begin
      mapped = 1'b0;
    end
  end

  assign accept = wr_acc && (idx == IDX_CTRL_SEC) && !busy && wdat[BIT_RESTART_REQUEST]
    && ctrl_pri[BIT_PORT_ENABLE];

  // Next values of sequencer and registers
  always_comb begin
    next_state = state;
    next_brg = baud_rate_generator;
    next_scl_oe = scl_oe;
    next_sda_oe = sda_oe;
    next_scl_d = I_SCL;
    next_sda_d = I_SDA;
    next_int_ctrl = int_ctrl;
    next_flags_one = flags_one;
    next_flags_two = flags_two;
    next_shift_buf = shift_buf;
    next_ctrl_pri = ctrl_pri;
    next_ena_one = ena_one;
    next_ena_two = ena_two;
    next_ctrl_sec = ctrl_sec;
    next_baud_reload = baud_reload;
    next_status = status;
    next_prdata = prdata;
    coll = 1'b0;
    done = 1'b0;

    if (rd_setup) begin
      next_prdata = {24'h000000, rmux};
    end

    // Software writes first, hardware events below override
    if (wr_acc) begin
      if (idx == IDX_INT_CTRL) begin
        next_int_ctrl = wdat;
      end else if (idx == IDX_FLAGS_ONE) begin
        next_flags_one = flags_one & ~(wdat & MASK_FLAGS_ONE);
      end else if (idx == IDX_FLAGS_TWO) begin
        next_flags_two = flags_two & ~(wdat & MASK_FLAGS_TWO);
      end else if (idx == IDX_SHIFT_BUF) begin
        if (busy) begin
          next_ctrl_pri[BIT_WRITE_COLLISION] = 1'b1; // see RQ13
        end else begin
          next_shift_buf = wdat; // see RQ15
        end
      end else if (idx == IDX_CTRL_PRI) begin
        next_ctrl_pri = wdat;
        if (busy) begin
          next_ctrl_pri[BIT_WRITE_COLLISION] = wdat[BIT_WRITE_COLLISION] | ctrl_pri[BIT_WRITE_COLLISION];
        end
      end else if (idx == IDX_ENABLES_ONE) begin
        next_ena_one = wdat;
      end else if (idx == IDX_ENABLES_TWO) begin
        next_ena_two = wdat;
      end else if (idx == IDX_CTRL_SEC) begin
        next_ctrl_sec[7:CMD_BITS] = wdat[7:CMD_BITS];
        if (!busy) begin
          next_ctrl_sec[CMD_BITS-1:0] = wdat[CMD_BITS-1:0]; // see RQ14
          next_ctrl_sec[BIT_RESTART_REQUEST] = accept; // see RQ10
        end
      end else if (idx == IDX_BAUD_RELOAD) begin
        next_baud_reload = wdat;
      end else if (idx == IDX_STATUS) begin
        next_status = (status & ~MASK_STATUS_WR) | (wdat & MASK_STATUS_WR); // see RQ17
      end
    end

    if (start_det) begin
      next_status[BIT_START_SEEN] = 1'b1; // see RQ7
      next_status[BIT_STOP_SEEN] = 1'b0;
    end else if (stop_det) begin
      next_status[BIT_STOP_SEEN] = 1'b1;
      next_status[BIT_START_SEEN] = 1'b0;
    end

    case (state)
      ST_IDLE, ST_HOLD: begin
        if (accept) begin
          next_scl_oe = 1'b1; // see RQ1
          next_state = ST_CLK_DOWN;
        end
      end
      ST_CLK_DOWN: begin
        if (!I_SCL) begin
          next_brg = baud_reload[BAUD_BITS-1:0]; // see RQ2
          next_sda_oe = 1'b0; // see RQ3
          next_state = ST_DATA_UP;
        end
      end
      ST_DATA_UP: begin
        if (baud_rate_generator != RST_BAUD_COUNT) begin
          next_brg = baud_rate_generator - 7'h01;
        end else if (I_SDA) begin
          next_scl_oe = 1'b0; // see RQ4
          next_state = ST_CLK_UP;
        end
      end
      ST_CLK_UP: begin
        if (I_SCL) begin
          if (!I_SDA) begin
            coll = 1'b1; // see RQ11
          end else begin
            next_brg = baud_reload[BAUD_BITS-1:0]; // see RQ5
            next_state = ST_BOTH_HIGH;
          end
        end
      end
      ST_BOTH_HIGH: begin
        if (!I_SCL) begin
          coll = 1'b1; // see RQ12
        end else if (baud_rate_generator != RST_BAUD_COUNT) begin
          next_brg = baud_rate_generator - 7'h01; // see RQ5
        end else begin
          next_sda_oe = 1'b1; // see RQ6
          next_state = ST_START_WAIT;
        end
      end
      ST_START_WAIT: begin
        if (!I_SCL) begin
          coll = 1'b1; // see RQ12
        end else if (start_det) begin
          next_brg = baud_reload[BAUD_BITS-1:0]; // see RQ7
          next_state = ST_DATA_DOWN;
        end
      end
      ST_DATA_DOWN: begin
        if (baud_rate_generator != RST_BAUD_COUNT) begin
          next_brg = baud_rate_generator - 7'h01; // see RQ6
        end else begin
          done = 1'b1;
          next_scl_oe = 1'b1; // see RQ8
          next_ctrl_sec[BIT_RESTART_REQUEST] = 1'b0; // see RQ8
          next_state = ST_HOLD;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase

    if (done) begin
      next_flags_one[BIT_SERIAL_IRQ] = 1'b1; // see RQ9
    end

    if (coll) begin
      next_scl_oe = 1'b0; // see RQ18
      next_sda_oe = 1'b0;
      next_ctrl_sec[BIT_RESTART_REQUEST] = 1'b0;
      next_flags_two[BIT_BUS_COLLISION] = 1'b1;
      next_state = ST_IDLE;
    end

    // Disabling the port drops the bus at once
    if (!next_ctrl_pri[BIT_PORT_ENABLE]) begin
      next_scl_oe = 1'b0;
      next_sda_oe = 1'b0;
      next_ctrl_sec[BIT_RESTART_REQUEST] = 1'b0;
      next_state = ST_IDLE;
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (I_SYS_RST) begin
      state <= ST_IDLE;
      baud_rate_generator <= RST_BAUD_COUNT;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      int_ctrl <= RST_REG;
      flags_one <= RST_REG;
      flags_two <= RST_REG;
      shift_buf <= RST_BUF;
      ctrl_pri <= RST_REG;
      ena_one <= RST_REG;
      ena_two <= RST_REG;
      ctrl_sec <= RST_REG;
      baud_reload <= RST_REG;
      status <= RST_REG;
      prdata <= 32'h00000000;
    end else begin
      state <= next_state;
      baud_rate_generator <= next_brg;
      scl_oe <= next_scl_oe;
      sda_oe <= next_sda_oe;
      scl_d <= next_scl_d;
      sda_d <= next_sda_d;
      int_ctrl <= next_int_ctrl;
      flags_one <= next_flags_one;
      flags_two <= next_flags_two;
      shift_buf <= next_shift_buf;
      ctrl_pri <= next_ctrl_pri;
      ena_one <= next_ena_one;
      ena_two <= next_ena_two;
      ctrl_sec <= next_ctrl_sec;
      baud_reload <= next_baud_reload;
      status <= next_status;
      prdata <= next_prdata;
    end
  end

  assign O_PRDATA = prdata;
  assign O_PREADY = I_PSEL && I_PENABLE;
  assign O_PSLVERR = I_PSEL && I_PENABLE && !mapped;
  assign O_SCL = 1'b0;
  assign O_SDA = 1'b0;
  assign O_SCL_OE = scl_oe;
  assign O_SDA_OE = sda_oe;
  assign O_SLEW_LIMIT = status[BIT_SLEW_CONTROL]; // see RQ17
  assign O_IRQ = |(flags_one & ena_one) || |(flags_two & ena_two);

  // Checks
  sequence s_last_tick;
    state == ST_DATA_DOWN && baud_rate_generator == RST_BAUD_COUNT && ctrl_pri[BIT_PORT_ENABLE];
  endsequence

  sequence s_locked_write;
    busy && wr_acc && idx == IDX_CTRL_SEC && !done && !coll;
  endsequence

  a_req_pulls_clock: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST) // see RQ1
    accept && next_ctrl_pri[BIT_PORT_ENABLE] |=> state == ST_CLK_DOWN && O_SCL_OE)
    else $error("restart request did not pull clock low");

  a_brg_loaded: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST) // see RQ2
    state == ST_CLK_DOWN && !I_SCL && ctrl_pri[BIT_PORT_ENABLE] && !wr_acc
    |=> state == ST_DATA_UP && baud_rate_generator == baud_reload[6:0])
    else $error("baud generator not loaded from reload value");

  a_data_released: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST) // see RQ3
    state == ST_DATA_UP |-> !O_SDA_OE && O_SCL_OE)
    else $error("data not released while clock held low");

  a_clock_gate: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST) // see RQ4
    state == ST_DATA_UP && baud_rate_generator == RST_BAUD_COUNT && !I_SDA && ctrl_pri[BIT_PORT_ENABLE] && !wr_acc
    |=> state == ST_DATA_UP && O_SCL_OE)
    else $error("clock released while data low");

  a_high_period: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST) // see RQ5
    $rose(state == ST_BOTH_HIGH) |-> !O_SDA_OE && !O_SCL_OE && baud_rate_generator == baud_reload[6:0])
    else $error("high period not started with both lines released");

  a_start_drive: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST) // see RQ6
    state == ST_START_WAIT || state == ST_DATA_DOWN |-> O_SDA_OE && !O_SCL_OE)
    else $error("start edge not driven with clock high");

  a_start_flag: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST) // see RQ7
    start_det |=> status[BIT_START_SEEN] && !status[BIT_STOP_SEEN])
    else $error("start detection did not set flag");

  a_sequence_end: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST) // see RQ8
    s_last_tick |=> !ctrl_sec[BIT_RESTART_REQUEST] && O_SCL_OE && flags_one[BIT_SERIAL_IRQ] && state == ST_HOLD)
    else $error("sequence end did not clear request and set flag");

  a_buf_locked: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST) // see RQ13
    busy && wr_acc && idx == IDX_SHIFT_BUF |=> ctrl_pri[BIT_WRITE_COLLISION] && shift_buf == $past(shift_buf))
    else $error("busy buffer write not discarded");

  a_cmd_locked: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST) // see RQ14
    s_locked_write ##1 ctrl_pri[BIT_PORT_ENABLE] |-> ctrl_sec[4:0] == $past(ctrl_sec[4:0]))
    else $error("command bits changed while busy");

  a_coll_abort: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST) // see RQ18
    coll |=> state == ST_IDLE && !O_SCL_OE && !O_SDA_OE && flags_two[BIT_BUS_COLLISION])
    else $error("collision did not abort and flag");

endmodule : irs_restart_master

// file: src/irs_pkg.sv
// Constants, register map and state codes for the repeated-start sequencer
// Behaviour
// RQ1: Restart request when idle pulls clock low
// RQ2: Clock seen low loads baud generator
// RQ3: Data released for one baud period
// RQ4: Release clock at timeout only if data high
// RQ5: Both lines high for one baud period
// RQ6: Drive data low with clock high, one period
// RQ7: Start seen sets flag, generator reloads
// RQ8: Third timeout clears request, pulls clock low
// RQ9: Completion sets serial port interrupt flag
// RQ10: Requests during busy sequence are ignored
// RQ11: Data low at clock rise is collision
// RQ12: Clock falling before data low is collision
// RQ13: Buffer write while busy discarded, flag set
// RQ14: Five low command bits locked while busy
// RQ15: Software may then load address byte
// RQ16: Software then sends address, data or reads; no shift logic here, the buffer only holds what software writes
// RQ17: Slew control bit limits pin slew rate
// RQ18: Collision aborts, releases lines, sets flag
package irs_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_INT_CTRL = 8'h0B;
  localparam logic [7:0] IDX_FLAGS_ONE = 8'h0C;
  localparam logic [7:0] IDX_FLAGS_TWO = 8'h0D;
  localparam logic [7:0] IDX_SHIFT_BUF = 8'h13;
  localparam logic [7:0] IDX_CTRL_PRI = 8'h14;
  localparam logic [7:0] IDX_ENABLES_ONE = 8'h8C;
  localparam logic [7:0] IDX_ENABLES_TWO = 8'h8D;
  localparam logic [7:0] IDX_CTRL_SEC = 8'h91;
  localparam logic [7:0] IDX_BAUD_RELOAD = 8'h93;
  localparam logic [7:0] IDX_STATUS = 8'h94;

  // Field positions
  localparam int BIT_RESTART_REQUEST = 1;
  localparam int BIT_START_SEEN = 3;
  localparam int BIT_STOP_SEEN = 4;
  localparam int BIT_CLOCK_EDGE = 6;
  localparam int BIT_SLEW_CONTROL = 7;
  localparam int BIT_WRITE_COLLISION = 7;
  localparam int BIT_PORT_ENABLE = 5;
  localparam int BIT_SERIAL_IRQ = 3;
  localparam int BIT_BUS_COLLISION = 3;
  localparam int CMD_BITS = 5;
  localparam int BAUD_BITS = 7;

  // Reset values
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [7:0] RST_BUF = 8'h00;
  localparam logic [6:0] RST_BAUD_COUNT = 7'h00;

  // Writable masks
  localparam logic [7:0] MASK_STATUS_WR = 8'hC0;
  localparam logic [7:0] MASK_FLAGS_ONE = 8'h08;
  localparam logic [7:0] MASK_FLAGS_TWO = 8'h08;

  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_CLK_DOWN = 8'h02,
    ST_DATA_UP = 8'h04,
    ST_CLK_UP = 8'h08,
    ST_BOTH_HIGH = 8'h10,
    ST_START_WAIT = 8'h20,
    ST_DATA_DOWN = 8'h40,
    ST_HOLD = 8'h80
  } irs_state_t;

endpackage : irs_pkg

// file: testbench/irs_bus_model.sv
// Open-drain bus model for the other devices on the two wires
`timescale 1ns/100ps
module irs_bus_model (
  // Design side drive
  input wire logic i_scl_oe,
  input wire logic i_scl_val,
  input wire logic i_sda_oe,
  input wire logic i_sda_val,
  // Other parties pulling low, also clock stretch
  input wire logic i_scl_hold,
  input wire logic i_sda_hold,
  // Wired levels with pull-ups
  output logic o_scl,
  output logic o_sda
);
  assign o_scl = !i_scl_hold && (!i_scl_oe || i_scl_val);
  assign o_sda = !i_sda_hold && (!i_sda_oe || i_sda_val);
endmodule : irs_bus_model

// file: testbench/tb_top.sv
// Register-level bench for the repeated-start sequencer
`timescale 1ns/100ps
module tb_top;
  import irs_pkg::*;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, er, sh, dh, mon_on;
  logic scl, sda, scl_oe, sda_oe, scl_v, sda_v, slew, irq, p_scl, p_sda;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  int err_total, checks, cyc, n_scl, n_sda, rl;
  logic [7:0] regs [10] = '{IDX_INT_CTRL, IDX_FLAGS_ONE, IDX_FLAGS_TWO, IDX_SHIFT_BUF, IDX_CTRL_PRI,
    IDX_ENABLES_ONE, IDX_ENABLES_TWO, IDX_CTRL_SEC, IDX_BAUD_RELOAD, IDX_STATUS};

  irs_restart_master irs_restart_master_inst (.I_SYS_CLK(clk), .I_SYS_RST(rst), .I_PSEL(psel),
    .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
    .O_PREADY(pready), .O_PSLVERR(pslverr), .I_SCL(scl), .O_SCL(scl_v), .O_SCL_OE(scl_oe), .I_SDA(sda),
    .O_SDA(sda_v), .O_SDA_OE(sda_oe), .O_SLEW_LIMIT(slew), .O_IRQ(irq));
  irs_bus_model irs_bus_model_inst (.i_scl_oe(scl_oe), .i_scl_val(scl_v), .i_sda_oe(sda_oe),
    .i_sda_val(sda_v), .i_scl_hold(sh), .i_sda_hold(dh), .o_scl(scl), .o_sda(sda));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : test_done

  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // The wait ends when pready is seen high
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    chk(pready, 32'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask : apb

  task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    chk(rd, exp);
  endtask : rdc

  task automatic wait_irq();
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 300) begin
      @(posedge clk);
      n++;
    end
    chk(irq, 32'h1);
  endtask : wait_irq

  // Phase lengths measured on the drive enables
  always @(posedge clk) begin
    cyc <= cyc + 1;
    n_scl <= (scl_oe === p_scl) ? n_scl + 1 : 1;
    n_sda <= (sda_oe === p_sda) ? n_sda + 1 : 1;
    p_scl <= scl_oe;
    p_sda <= sda_oe;
    if (mon_on && p_scl && !scl_oe) chk(n_sda >= rl + 1, 32'h1);
    if (mon_on && !p_sda && sda_oe) chk({scl, n_scl >= rl + 1}, 32'h3);
    if (mon_on && !p_scl && scl_oe && sda_oe) chk(n_sda >= rl + 1 && n_sda <= rl + 3, 32'h1);
    if (cyc == 20000) begin
      err_total++;
      test_done();
    end
  end

  initial begin
    {psel, penable, pwrite, sh, dh, mon_on} = '0;
    paddr = '0;
    pwdata = '0;
    rst = 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    foreach (regs[i]) rdc(regs[i], 32'h0);
    apb(1'b1, 8'h20, 32'hFF);
    chk(er, 32'h1);
    rdc(8'h20, 32'h0);
    apb(1'b1, IDX_STATUS, 32'hFF);
    rdc(IDX_STATUS, 32'hC0);
    chk(slew, 32'h1);
    apb(1'b1, IDX_STATUS, 32'h00);
    rdc(IDX_STATUS, 32'h0);
    chk(slew, 32'h0);
    $display("registers and slew done");
    apb(1'b1, IDX_CTRL_PRI, 32'h20);
    apb(1'b1, IDX_ENABLES_ONE, 32'h08);
    apb(1'b1, IDX_ENABLES_TWO, 32'h08);
    apb(1'b1, IDX_SHIFT_BUF, 32'hC3);
    for (int i = 0; i < 2; i++) begin
      rl = i ? 0 : 3;
      apb(1'b1, IDX_BAUD_RELOAD, i ? 32'h00 : 32'h83);
      mon_on <= 1'b1;
      apb(1'b1, IDX_CTRL_SEC, 32'h02);
      if (i == 0) begin
        apb(1'b1, IDX_SHIFT_BUF, 32'h5A);
        apb(1'b1, IDX_CTRL_SEC, 32'h01);
        rdc(IDX_SHIFT_BUF, 32'hC3);
        rdc(IDX_CTRL_PRI, 32'hA0);
      end
      wait_irq();
      mon_on <= 1'b0;
      chk({scl_oe, sda_oe}, 32'h3);
      rdc(IDX_CTRL_SEC, 32'h0);
      rdc(IDX_STATUS, 32'h08);
      rdc(IDX_FLAGS_ONE, 32'h08);
      apb(1'b1, IDX_ENABLES_ONE, 32'h00);
      chk(irq, 32'h0);
      apb(1'b1, IDX_ENABLES_ONE, 32'h08);
      chk(irq, 32'h1);
      apb(1'b1, IDX_FLAGS_ONE, 32'h08);
      chk(irq, 32'h0);
      $display("restart %0d done", i);
    end
    apb(1'b1, IDX_CTRL_PRI, 32'h20);
    apb(1'b1, IDX_SHIFT_BUF, 32'hA6);
    rdc(IDX_SHIFT_BUF, 32'hA6);
    rdc(IDX_CTRL_PRI, 32'h20);
    apb(1'b1, IDX_BAUD_RELOAD, 32'h10);
    for (int k = 0; k < 2; k++) begin
      dh <= (k == 1);
      apb(1'b1, IDX_CTRL_SEC, 32'h02);
      if (k == 0) begin
        for (int n = 0; n < 300 && scl_oe !== 1'b0; n++) @(posedge clk);
        sh <= 1'b1;
      end else begin
        // Data held low at timeout keeps the clock driven
        repeat (40) @(posedge clk);
        chk(scl_oe, 32'h1);
        dh <= 1'b0;
        @(posedge clk);
        dh <= 1'b1;
      end
      wait_irq();
      chk({scl_oe, sda_oe}, 32'h0);
      rdc(IDX_FLAGS_TWO, 32'h08);
      rdc(IDX_CTRL_SEC, 32'h0);
      sh <= 1'b0;
      dh <= 1'b0;
      apb(1'b1, IDX_FLAGS_TWO, 32'h08);
      chk(irq, 32'h0);
      $display("collision %0d done", k);
    end
    test_done();
  end
endmodule : tb_top
